// file: hw/obp_pkg.sv
// obp_pkg: constants, field layouts and state types of the option byte
// programmer. assumes a 32-bit axi4-lite register bus at 20 mhz.
package obp_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OBP_OFS_KEY = 8'h00; // option_key_register
  localparam logic [7:0] OBP_OFS_CTRL = 8'h04; // option_control_register
  localparam logic [7:0] OBP_OFS_STAT = 8'h08; // flash_status_register
  localparam logic [7:0] OBP_OFS_MASK = 8'h0c; // interrupt mask
  localparam logic [7:0] OBP_OFS_USER = 8'h10; // user_option_word
  localparam logic [7:0] OBP_OFS_WPW = 8'h14; // write_protect_option_word
  localparam logic [7:0] OBP_OFS_CFG = 8'h18; // direct sector window
  // sector address of the write protection word, for software reference
  localparam logic [31:0] OBP_WPW_SECTOR_ADDR = 32'h1fffc008;

  // ------------------------------------------------------------------
  // keys and bit positions
  // ------------------------------------------------------------------
  localparam logic [31:0] OBP_FIRST_KEY = 32'h08192a3b;
  localparam logic [31:0] OBP_SECOND_KEY = 32'h4c5d6e7f;
  localparam int OBP_CTRL_LOCK = 0;
  localparam int OBP_CTRL_START = 1;
  localparam int OBP_STAT_BUSY = 0;
  localparam int OBP_STAT_DONE = 1;
  localparam int OBP_STAT_WPERR = 2;
  localparam logic [15:0] OBP_ERASED = 16'hffff;
  localparam logic [7:0] OBP_RDP_L0 = 8'haa;
  localparam logic [7:0] OBP_RDP_L2 = 8'hcc;
  localparam logic [1:0] OBP_BOR_OFF = 2'b11;

  // ------------------------------------------------------------------
  // reset values and operation lengths
  // ------------------------------------------------------------------
  localparam logic [7:0] OBP_RST_RDP = 8'haa;
  localparam logic [11:0] OBP_RST_WP = 12'hfff;
  localparam int OBP_ERASE_CYC = 16;
  localparam int OBP_PROG_CYC = 8;
  localparam logic [1:0] OBP_RESP_OKAY = 2'b00;
  localparam logic [1:0] OBP_RESP_SLVERR = 2'b10;

  // option fields as held in the control register
  typedef struct packed {
    logic [11:0] wp;   // sector_write_unprotect
    logic [7:0] read_protection_byte;   // read_protection_byte
    logic stdby;       // standby_reset_disable
    logic stop;        // stop_reset_disable
    logic wdg;         // watchdog_soft_select
    logic [1:0] bor;   // brownout_level
  } obp_opt_t;

  // decoded option settings driven to the rest of the chip
  typedef struct packed {
    logic [11:0] sector_write_unprotect;
    logic [1:0] rdp_level;
    logic [1:0] brownout_level;
    logic brownout_enable;
    logic watchdog_hw_start;
  } obp_cfg_t;

  typedef enum logic [2:0] {
    OBP_IDLE = 3'b001,
    OBP_ERASE = 3'b010,
    OBP_PROG = 3'b100
  } obp_phase_t;

  typedef struct packed {
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic lock;
    logic key_stage;
    obp_opt_t opt;
    obp_phase_t phase;
    logic [4:0] count;
    logic [15:0] user_word;
    logic [15:0] wp_word;
    logic done;
    logic wperr;
    logic [2:0] mask;
    logic lp_reset;
  } obp_state_t;

endpackage

// file: hw/obp_top.sv
// obp_top: option byte programmer with axi4-lite slave, key unlock,
// erase-then-program update and the decoded option outputs.
// assumes one clock, axi signals synchronous to it, and low-power entry
// strobes as one-cycle pulses from the power controller.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module obp_top
  import obp_pkg::*;
#(
  parameter int ERASE_CYC = OBP_ERASE_CYC, // erase phase length
  parameter int PROG_CYC = OBP_PROG_CYC    // program phase length
)
(
  input wire logic clk_i,                   // 20 mhz clock
  input wire logic rst_b_i,                 // async reset, active low
  input wire logic s_axi_awvalid_i,         // write address valid
  output logic s_axi_awready_o,             // write address ready
  input wire logic [7:0] s_axi_awaddr_i,    // write byte address
  input wire logic s_axi_wvalid_i,          // write data valid
  output logic s_axi_wready_o,              // write data ready
  input wire logic [31:0] s_axi_wdata_i,    // write data
  input wire logic [3:0] s_axi_wstrb_i,     // byte strobes
  output logic s_axi_bvalid_o,              // write response valid
  input wire logic s_axi_bready_i,          // write response ready
  output logic [1:0] s_axi_bresp_o,         // write response
  input wire logic s_axi_arvalid_i,         // read address valid
  output logic s_axi_arready_o,             // read address ready
  input wire logic [7:0] s_axi_araddr_i,    // read byte address
  output logic s_axi_rvalid_o,              // read data valid
  input wire logic s_axi_rready_i,          // read data ready
  output logic [31:0] s_axi_rdata_o,        // read data
  output logic [1:0] s_axi_rresp_o,         // read response
  input wire logic standby_entry_i,         // pulse: entering standby
  input wire logic stop_entry_i,            // pulse: entering stop
  output logic lowpower_reset_o,            // pulse: reset on mode entry
  output obp_pkg::obp_cfg_t option_cfg_o,   // decoded stored options
  output logic operation_busy_o,            // update in progress
  output logic irq_o                        // level interrupt
);
  import obp_pkg::*;

  localparam logic [4:0] ERASE_LAST = 5'(ERASE_CYC - 1);
  localparam logic [4:0] PROG_LAST = 5'(PROG_CYC - 1);

  obp_state_t st_ff;
  obp_state_t nxt_st;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------

  // read protection level from the stored byte
  function automatic logic [1:0] rdp_level(input logic [7:0] b);
    if (b == OBP_RDP_L0)
      rdp_level = 2'd0;
    else if (b == OBP_RDP_L2)
      rdp_level = 2'd2;
    else
      rdp_level = 2'd1;
  endfunction

  // user word image, unused bits forced to one
  function automatic logic [15:0] user_image(input obp_opt_t o);
    user_image = {o.read_protection_byte, o.stdby, o.stop, o.wdg, 1'b1, o.bor, 2'b11};
  endfunction

  // protection word image, unused top nibble forced to one
  function automatic logic [15:0] wp_image(input obp_opt_t o);
    wp_image = {4'hf, o.wp};
  endfunction

  // control register view; start always reads back as zero
  function automatic logic [31:0] ctrl_view(input obp_state_t s);
    ctrl_view = {4'h0, s.opt.wp, s.opt.read_protection_byte, s.opt.stdby, s.opt.stop,
                 s.opt.wdg, 1'b0, s.opt.bor, 1'b0, s.lock};
  endfunction

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------

  // one write and one read at most in flight; a write is performed in
  // the cycle both halves are held, the response comes one cycle later
  always_comb
  begin
    logic do_write;
    logic full_word;
    logic start_req;
    logic [2:0] w1c;
    obp_opt_t wopt;
    nxt_st = st_ff;
    do_write = 1'b0;
    full_word = 1'b0;
    start_req = 1'b0;
    w1c = 3'b000;
    wopt = st_ff.opt;

    // capture write address and data in either order
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      nxt_st.aw_have = 1'b1;
      nxt_st.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      nxt_st.w_have = 1'b1;
      nxt_st.wdata = s_axi_wdata_i;
      nxt_st.wstrb = s_axi_wstrb_i;
    end
    if (s_axi_bvalid_o && s_axi_bready_i)
      nxt_st.bvalid = 1'b0;

    do_write = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
    // partial-word writes are answered; only a sector window write still sets wperr
    full_word = (st_ff.wstrb == 4'hf);
    if (do_write)
    begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = OBP_RESP_OKAY;
      unique case (st_ff.awaddr[7:2])
        OBP_OFS_KEY[7:2]:
          if (full_word && st_ff.lock)
          begin
            if (!st_ff.key_stage && st_ff.wdata == OBP_FIRST_KEY)
              nxt_st.key_stage = 1'b1;
            else if (st_ff.key_stage && st_ff.wdata == OBP_SECOND_KEY)
            begin
              nxt_st.key_stage = 1'b0;
              nxt_st.lock = 1'b0;
            end
            else
              nxt_st.key_stage = 1'b0;
          end
        OBP_OFS_CTRL[7:2]:
          if (full_word)
          begin
            // setting the lock always works, even mid-update
            if (st_ff.wdata[OBP_CTRL_LOCK])
            begin
              nxt_st.lock = 1'b1;
              nxt_st.key_stage = 1'b0;
            end
            else if (!st_ff.lock && st_ff.phase == OBP_IDLE)
            begin
              wopt.wp = st_ff.wdata[27:16];
              wopt.read_protection_byte = st_ff.wdata[15:8];
              wopt.stdby = st_ff.wdata[7];
              wopt.stop = st_ff.wdata[6];
              wopt.wdg = st_ff.wdata[5];
              wopt.bor = st_ff.wdata[3:2];
              nxt_st.opt = wopt;
              start_req = st_ff.wdata[OBP_CTRL_START];
            end
          end
        OBP_OFS_STAT[7:2]:
          if (full_word)
            w1c = st_ff.wdata[2:0];
        OBP_OFS_MASK[7:2]:
          if (full_word)
            nxt_st.mask = st_ff.wdata[2:0];
        OBP_OFS_USER[7:2], OBP_OFS_WPW[7:2]:
          nxt_st.bresp = OBP_RESP_OKAY; // read-only, write ignored
        OBP_OFS_CFG[7:2]:
          nxt_st.bresp = OBP_RESP_OKAY; // flagged below, never stored
        default:
          nxt_st.bresp = OBP_RESP_SLVERR;
      endcase
    end

    // status flags: a hardware set wins over a same-cycle clear
    if (w1c[OBP_STAT_DONE])
      nxt_st.done = 1'b0;
    if (w1c[OBP_STAT_WPERR])
      nxt_st.wperr = 1'b0;
    if (do_write && st_ff.awaddr[7:2] == OBP_OFS_CFG[7:2])
      nxt_st.wperr = 1'b1;

    // erase then program sequence
    nxt_st.count = st_ff.count + 5'd1;
    unique case (st_ff.phase)
      OBP_IDLE:
      begin
        nxt_st.count = 5'd0;
        if (start_req)
          nxt_st.phase = OBP_ERASE;
      end
      OBP_ERASE:
        if (st_ff.count == ERASE_LAST)
        begin
          nxt_st.user_word = OBP_ERASED;
          nxt_st.wp_word = OBP_ERASED;
          nxt_st.count = 5'd0;
          nxt_st.phase = OBP_PROG;
        end
      OBP_PROG:
        if (st_ff.count == PROG_LAST)
        begin
          // every byte from the control register, bor included
          nxt_st.user_word = user_image(st_ff.opt);
          nxt_st.wp_word = wp_image(st_ff.opt);
          nxt_st.count = 5'd0;
          nxt_st.phase = OBP_IDLE;
          nxt_st.done = 1'b1;
        end
    endcase

    // read channel: data registered, one cycle after the address
    if (s_axi_rvalid_o && s_axi_rready_i)
      nxt_st.rvalid = 1'b0;
    if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = OBP_RESP_OKAY;
      unique case (s_axi_araddr_i[7:2])
        OBP_OFS_KEY[7:2]:
          nxt_st.rdata = 32'h0; // key register is write-only
        OBP_OFS_CTRL[7:2]:
          nxt_st.rdata = ctrl_view(st_ff);
        OBP_OFS_STAT[7:2]:
          nxt_st.rdata = {29'h0, st_ff.wperr, st_ff.done,
                          st_ff.phase != OBP_IDLE};
        OBP_OFS_MASK[7:2]:
          nxt_st.rdata = {29'h0, st_ff.mask};
        OBP_OFS_USER[7:2]:
          nxt_st.rdata = {16'h0, st_ff.user_word};
        OBP_OFS_WPW[7:2]:
          nxt_st.rdata = {16'h0, st_ff.wp_word};
        OBP_OFS_CFG[7:2]:
          nxt_st.rdata = {16'h0, st_ff.user_word};
        default:
        begin
          nxt_st.rdata = 32'h0;
          nxt_st.rresp = OBP_RESP_SLVERR;
        end
      endcase
    end

    // low-power reset from the stored bits, not the pending ones
    nxt_st.lp_reset =
      (standby_entry_i && !st_ff.user_word[7]) ||
      (stop_entry_i && !st_ff.user_word[6]);
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------

  // the store model is volatile flops; reset loads an unprotected image
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_ff <= '0;
      st_ff.lock <= 1'b1;
      st_ff.opt <= '{wp: OBP_RST_WP, read_protection_byte: OBP_RST_RDP, stdby: 1'b1,
                     stop: 1'b1, wdg: 1'b1, bor: OBP_BOR_OFF};
      st_ff.phase <= OBP_IDLE;
      st_ff.user_word <= {OBP_RST_RDP, 8'hff};
      st_ff.wp_word <= OBP_ERASED;
    end
    else
      st_ff <= nxt_st;
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------

  // handshakes: one item per channel until the response is taken
  assign s_axi_awready_o = !st_ff.aw_have && !st_ff.bvalid;
  assign s_axi_wready_o = !st_ff.w_have && !st_ff.bvalid;
  assign s_axi_bvalid_o = st_ff.bvalid;
  assign s_axi_bresp_o = st_ff.bresp;
  assign s_axi_arready_o = !st_ff.rvalid;
  assign s_axi_rvalid_o = st_ff.rvalid;
  assign s_axi_rdata_o = st_ff.rdata;
  assign s_axi_rresp_o = st_ff.rresp;
  assign lowpower_reset_o = st_ff.lp_reset;
  assign operation_busy_o = (st_ff.phase != OBP_IDLE);
  assign irq_o = |({st_ff.wperr, st_ff.done, 1'b0} & st_ff.mask);

  // decoded options straight from the stored words
  assign option_cfg_o.sector_write_unprotect = st_ff.wp_word[11:0];
  assign option_cfg_o.rdp_level = rdp_level(st_ff.user_word[15:8]);
  assign option_cfg_o.brownout_level = st_ff.user_word[3:2];
  assign option_cfg_o.brownout_enable =
    (st_ff.user_word[3:2] != OBP_BOR_OFF);
  assign option_cfg_o.watchdog_hw_start = !st_ff.user_word[5];

endmodule

`default_nettype wire

// file: tb/obp_checker_properties.sv
// obp_checker: timing assertions watching the ports of obp_top.
// assumes one clock domain and the async active-low reset of obp_top.
`timescale 1ns/1ns
`default_nettype none
module obp_checker
#(
  parameter int ERASE_CYC = obp_pkg::OBP_ERASE_CYC, // erase length
  parameter int PROG_CYC = obp_pkg::OBP_PROG_CYC    // program length
)
(
  input wire logic clk_i,                   // clock
  input wire logic rst_b_i,                 // reset, active low
  input wire logic s_axi_awvalid_i,         // aw valid
  input wire logic s_axi_awready_o,         // aw ready
  input wire logic s_axi_wvalid_i,          // w valid
  input wire logic s_axi_wready_o,          // w ready
  input wire logic s_axi_bvalid_o,          // b valid
  input wire logic s_axi_bready_i,          // b ready
  input wire logic [1:0] s_axi_bresp_o,     // b response
  input wire logic s_axi_arvalid_i,         // ar valid
  input wire logic s_axi_arready_o,         // ar ready
  input wire logic s_axi_rvalid_o,          // r valid
  input wire logic s_axi_rready_i,          // r ready
  input wire logic [31:0] s_axi_rdata_o,    // r data
  input wire logic standby_entry_i,         // standby entry
  input wire logic stop_entry_i,            // stop entry
  input wire logic lowpower_reset_o,        // mode entry reset
  input wire obp_pkg::obp_cfg_t option_cfg_o, // decoded options
  input wire logic operation_busy_o,        // update running
  input wire logic irq_o                    // interrupt
);
  import obp_pkg::*;
  // ------------------------------------------------------------------
  // busy length counter
  // ------------------------------------------------------------------
  logic [6:0] bcnt_ff;
  // counts busy cycles; a slip of one in either phase shows at the end
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i) bcnt_ff <= 7'h00;
    else if (!operation_busy_o) bcnt_ff <= 7'h00;
    else bcnt_ff <= bcnt_ff + 7'h01;
  end
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_busy_len: assert property (
    $fell(operation_busy_o) |-> bcnt_ff == 7'(ERASE_CYC + PROG_CYC))
    else $error("update busy length wrong");
  chk_lp_cause: assert property (
    lowpower_reset_o |-> $past(standby_entry_i) || $past(stop_entry_i))
    else $error("mode reset without entry");
  chk_bor_enable: assert property (
    option_cfg_o.brownout_enable == (option_cfg_o.brownout_level != 2'h3))
    else $error("brownout enable decode wrong");
  chk_cfg_stable: assert property (
    !operation_busy_o && !$past(operation_busy_o) |-> $stable(option_cfg_o))
    else $error("options changed outside update");
  chk_aw_block: assert property (
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while response pending");
  chk_b_hold: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
      && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  chk_r_hold: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
      && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  chk_read_lat: assert property (
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  chk_write_lat: assert property (
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |-> ##2 s_axi_bvalid_o)
    else $error("write answer late");
  cover property ($fell(operation_busy_o));
  cover property (lowpower_reset_o);
  cover property ($rose(irq_o));
endmodule
bind obp_top obp_checker #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC))
  u_obp_checker (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
  .standby_entry_i(standby_entry_i), .stop_entry_i(stop_entry_i),
  .lowpower_reset_o(lowpower_reset_o), .option_cfg_o(option_cfg_o),
  .operation_busy_o(operation_busy_o), .irq_o(irq_o));
`default_nettype wire

// file: tb/option_byte_programmer_test.sv
// option_byte_programmer_test: register-level bench of obp_top.
// assumes obp_pkg, obp_top and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module option_byte_programmer_test;
  import obp_pkg::*;
  // short phases keep the run brief; expectations use the same values
  localparam int EC = 4;
  localparam int PC = 4;
  logic clk_i = 1'b0, rst_b_i = 1'b0, ent_d = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic sb = 1'b0, st = 1'b0, awr, wrd, bv, arr, rv, lp, busy, irq;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [3:0] ws = 4'hf;
  logic [1:0] br, rr;
  obp_cfg_t cfg;
  obp_opt_t o;
  logic [7:0] rdps [4] = '{8'haa, 8'hcc, 8'h00, 8'h5a};
  logic [33:0] rq [$];
  logic [1:0] bq [$];
  logic lq [$];
  int n_mismatch = 0, samples_checked = 0, seed = 72, cyc = 0;
  obp_top #(.ERASE_CYC(EC), .PROG_CYC(PC)) u_obp_top (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bre), .s_axi_bresp_o(br), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rre), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr),
    .standby_entry_i(sb), .stop_entry_i(st), .lowpower_reset_o(lp),
    .option_cfg_o(cfg), .operation_busy_o(busy), .irq_o(irq));
  // ------------------------------------------------------------------
  // compare and report
  // ------------------------------------------------------------------
  task automatic note(input string nm, input logic [33:0] e, g);
    samples_checked++;
    if (e !== g)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_rd(input logic [33:0] e, g); note("rdata", e, g);
  endtask
  task automatic cmp_b(input logic [1:0] e, g); note("bresp", e, g);
  endtask
  task automatic cmp_out(input string nm, input logic [17:0] e, g);
    note(nm, e, g);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // clock, timeout and result monitor
  // ------------------------------------------------------------------
  always #25 clk_i = ~clk_i;
  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge clk_i)
  begin
    cyc++;
    ent_d <= sb | st;
    if (cyc == 5000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  // results are taken at the falling edge, where every output has settled
  always @(negedge clk_i)
  begin
    if (rv && rre) cmp_rd(rq.pop_front(), {rr, rdat});
    if (bv && bre) cmp_b(bq.pop_front(), br);
    if (ent_d) cmp_out("lowpower", 18'(lq.pop_front()), 18'(lp));
  end
  // ------------------------------------------------------------------
  // bus and pin tasks
  // ------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = OBP_RESP_OKAY);
    logic ha, hw, hb;
    bq.push_back(r);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do
    begin
      @(negedge clk_i);
      ha = awv & awr;
      hw = wv & wrd;
      hb = bv;
      @(posedge clk_i);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
    end while (!hb);
    bre <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r = OBP_RESP_OKAY);
    logic h, hr;
    rq.push_back({r, e});
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do
    begin
      @(negedge clk_i);
      h = arv & arr;
      hr = rv;
      @(posedge clk_i);
      if (h) arv <= 1'b0;
    end while (!hr);
    rre <= 1'b0;
  endtask
  task automatic see(input string nm, input logic e);
    @(negedge clk_i);
    cmp_out(nm, 18'(e), (nm == "irq") ? 18'(irq) : 18'(busy));
    @(posedge clk_i);
  endtask
  task automatic pulse(input logic s, input logic e);
    lq.push_back(e);
    if (s) sb <= 1'b1;
    else st <= 1'b1;
    @(posedge clk_i);
    sb <= 1'b0;
    st <= 1'b0;
    @(posedge clk_i);
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    rd(OBP_OFS_USER, 32'h0000aaff);
    rd(OBP_OFS_WPW, 32'h0000ffff);
    rd(OBP_OFS_KEY, 32'h0);
    rd(8'h1c, 32'h0, OBP_RESP_SLVERR);
    wr(8'h1c, 32'h1, OBP_RESP_SLVERR);
    wr(OBP_OFS_CTRL, 32'h00aa0002);
    see("busy", 1'b0);
    rd(OBP_OFS_CTRL, 32'h0fffaaed);
    wr(OBP_OFS_KEY, OBP_SECOND_KEY);
    wr(OBP_OFS_KEY, OBP_FIRST_KEY);
    wr(OBP_OFS_KEY, OBP_FIRST_KEY ^ 32'h1);
    wr(OBP_OFS_KEY, OBP_SECOND_KEY);
    rd(OBP_OFS_CTRL, 32'h0fffaaed);
    wr(OBP_OFS_KEY, OBP_FIRST_KEY);
    wr(OBP_OFS_KEY, OBP_SECOND_KEY);
    rd(OBP_OFS_CTRL, 32'h0fffaaec);
    ws <= 4'h3;
    wr(OBP_OFS_MASK, 32'h7);
    ws <= 4'hf;
    rd(OBP_OFS_MASK, 32'h0);
    wr(OBP_OFS_CFG, 32'h0);
    rd(OBP_OFS_STAT, 32'h4);
    see("irq", 1'b0);
    wr(OBP_OFS_MASK, 32'h4);
    see("irq", 1'b1);
    wr(OBP_OFS_STAT, 32'h4);
    see("irq", 1'b0);
    rd(OBP_OFS_USER, 32'h0000aaff);
    // every brownout code and read protection class, done irq masked
    for (int i = 0; i < 4; i++)
    begin
      o.wp = 12'($random(seed));
      o.read_protection_byte = rdps[i];
      o.stdby = i[0];
      o.stop = ~i[0];
      o.wdg = i[1];
      o.bor = 2'(i);
      rd(OBP_OFS_STAT, 32'h0);
      wr(OBP_OFS_CTRL, {4'h0, o.wp, o.read_protection_byte, o.stdby, o.stop, o.wdg,
                        1'b0, o.bor, 2'b10});
      rd(OBP_OFS_STAT, 32'h1);
      for (int k = 0; k < 99 && busy !== 1'b0; k++) @(posedge clk_i);
      rd(OBP_OFS_STAT, 32'h2);
      see("irq", 1'b0);
      wr(OBP_OFS_STAT, 32'h2);
      rd(OBP_OFS_USER, {16'h0, o.read_protection_byte, o.stdby, o.stop, o.wdg, 1'b1,
                        o.bor, 2'b11});
      rd(OBP_OFS_WPW, {16'h0, 4'hf, o.wp});
      @(negedge clk_i);
      cmp_out("cfg", {o.wp, (o.read_protection_byte == 8'haa) ? 2'h0 : (o.read_protection_byte == 8'hcc)
              ? 2'h2 : 2'h1, o.bor, o.bor != 2'h3, !o.wdg},
              cfg);
      @(posedge clk_i);
      pulse(1'b1, !o.stdby);
      pulse(1'b0, !o.stop);
    end
    wr(OBP_OFS_CTRL, 32'h1);
    wr(OBP_OFS_CTRL, 32'h2);
    see("busy", 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
